// File: hw/umsfc_top.sv
// Modem handshake status and FIFO control for one serial port.
// Assumes synchronous modem inputs and a plain register port.
//
// Overview of operation
// - Bit 7 is inverted carrier, loopback ctrl bit 3
// - Bit 6 is inverted ring, loopback ctrl bit 2
// - Bit 5 is inverted set-ready, loopback bit 0
// - Bit 4 is inverted clear-to-send, loopback bit 1
// - Carrier change sets flag bit 3
// - Ring pin low-to-high sets flag bit 2
// - Set-ready change sets flag bit 1
// - Clear-to-send change sets flag bit 0
// - FIFO control register cannot be read back
// - Control bit 0 enables FIFO mode
// - Bit 3 with enable selects DMA mode 1
// - Bit 2 rising resets transmit FIFO counters
// - Bit 1 rising resets receive FIFO counters
// - Bits 7:6 pick receive trigger level
// - Mode 00 gives 1, 4, 8, 14
// - Other modes give upper level tables
// - Control bit 4 selects internal loopback
// - Change flags raise modem interrupt if enabled
// - Identity bits 7:6 show FIFO enable
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module umsfc_top
  import umsfc_pkg::*;
(
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RST,
  input  wire logic [3:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  input  wire logic       I_DCD_N,
  input  wire logic       I_RI_N,
  input  wire logic       I_DSR_N,
  input  wire logic       I_CTS_N,
  output logic      [7:0] O_RDATA,
  output logic            O_DTR_N,
  output logic            O_RTS_N,
  output logic            O_FIFO_EN,
  output logic            O_DMA_MODE1,
  output logic            O_TX_FIFO_RST,
  output logic            O_RX_FIFO_RST,
  output logic      [6:0] O_RX_TRIG_LEVEL,
  output logic            O_MODEM_IRQ
);
  import umsfc_pkg::*;

  umsfc_req_s   req;
  umsfc_modem_s live;
  umsfc_modem_s prev_ff;
  umsfc_modem_s nxt_prev;
  logic         prev_vld_ff;
  logic [7:0]   hcr_ff;
  logic [7:0]   nxt_hcr;
  logic [7:0]   fcr_ff;
  logic [7:0]   nxt_fcr;
  logic [7:0]   icr_ff;
  logic [7:0]   nxt_icr;
  logic [1:0]   mode_ff;
  logic [1:0]   nxt_mode;
  logic [3:0]   delta_ff;
  logic [3:0]   nxt_delta;
  logic [3:0]   events;
  logic [7:0]   rdata_ff;
  logic [7:0]   nxt_rdata;
  logic         tx_rst_ff;
  logic         nxt_tx_rst;
  logic         rx_rst_ff;
  logic         nxt_rx_rst;
  logic         irq_ff;
  logic         nxt_irq;
  logic         wr_fcr;
  logic         rd_hsr;

  assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
  assign wr_fcr = req.wr && (req.addr == ADDR_FIFO_CTRL);
  assign rd_hsr = req.rd && (req.addr == ADDR_HANDSHAKE_STAT);

  // Modem levels: pins inverted, or control bits in loopback
  always_comb
  begin
    if (hcr_ff[HCR_LOOPBACK])
    begin
      live.dcd = hcr_ff[HCR_IRQ_EN];
      live.ri  = hcr_ff[HCR_LOOP_RI];
      live.dsr = hcr_ff[HCR_DTR];
      live.cts = hcr_ff[HCR_RTS];
    end
    else
    begin
      live.dcd = ~I_DCD_N;
      live.ri  = ~I_RI_N;
      live.dsr = ~I_DSR_N;
      live.cts = ~I_CTS_N;
    end
  end

  // Change detection; ring flags when the pin goes low to high,
  // i.e. when the active-high ring level falls
  always_comb
  begin
    events[3] = prev_vld_ff && (live.dcd != prev_ff.dcd);
    events[2] = prev_vld_ff && prev_ff.ri && !live.ri;
    events[1] = prev_vld_ff && (live.dsr != prev_ff.dsr);
    events[0] = prev_vld_ff && (live.cts != prev_ff.cts);
    nxt_prev = live;
    // Read clears, but a same-cycle event survives
    nxt_delta = (rd_hsr ? 4'h0 : delta_ff) | events;
  end

  // Control register writes
  always_comb
  begin
    nxt_hcr  = hcr_ff;
    nxt_fcr  = fcr_ff;
    nxt_icr  = icr_ff;
    nxt_mode = mode_ff;
    if (req.wr)
    begin
      case (req.addr)
        ADDR_HANDSHAKE_CTRL: nxt_hcr = {3'h0, req.wdata[4:0]};
        ADDR_FIFO_CTRL:      nxt_fcr = {req.wdata[7:6], 2'h0,
                                        req.wdata[3:0]};
        ADDR_INT_CTRL:       nxt_icr = {4'h0, req.wdata[3:0]};
        ADDR_LEVEL_MODE:     nxt_mode = req.wdata[7:6];
        default:             nxt_hcr = hcr_ff;
      endcase
    end
    // One-cycle counter reset pulses on a rising control bit
    nxt_tx_rst = wr_fcr && req.wdata[FCR_TX_RST]
                 && !fcr_ff[FCR_TX_RST];
    nxt_rx_rst = wr_fcr && req.wdata[FCR_RX_RST]
                 && !fcr_ff[FCR_RX_RST];
    nxt_irq = icr_ff[ICR_MODEM_EN] && (delta_ff != 4'h0);
  end

  // Read data, one cycle after the strobe
  always_comb
  begin
    nxt_rdata = READ_ZERO;
    if (req.rd)
    begin
      case (req.addr)
        ADDR_HANDSHAKE_STAT:
          nxt_rdata = {live.dcd, live.ri, live.dsr, live.cts, delta_ff};
        ADDR_HANDSHAKE_CTRL: nxt_rdata = hcr_ff;
        ADDR_INT_CTRL:       nxt_rdata = icr_ff;
        ADDR_LEVEL_MODE:     nxt_rdata = {mode_ff, 6'h00};
        // Shares the FIFO control offset; control value never returned
        ADDR_INT_IDENT:
          nxt_rdata = {(fcr_ff[FCR_ENABLE] ? FIFO_ON_ID : 2'h0),
                       2'h0,
                       (icr_ff[ICR_MODEM_EN] && delta_ff != 4'h0)
                         ? IID_MODEM : IID_NONE};
        default:             nxt_rdata = READ_ZERO;
      endcase
    end
  end

  // State registers
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      hcr_ff      <= HCR_RESET;
      fcr_ff      <= FCR_RESET;
      icr_ff      <= ICR_RESET;
      mode_ff     <= MODE_RESET;
      delta_ff    <= 4'h0;
      prev_ff     <= '0;
      prev_vld_ff <= 1'b0;
      rdata_ff    <= READ_ZERO;
      tx_rst_ff   <= 1'b0;
      rx_rst_ff   <= 1'b0;
      irq_ff      <= 1'b0;
    end
    else
    begin
      hcr_ff      <= nxt_hcr;
      fcr_ff      <= nxt_fcr;
      icr_ff      <= nxt_icr;
      mode_ff     <= nxt_mode;
      delta_ff    <= nxt_delta;
      prev_ff     <= nxt_prev;
      prev_vld_ff <= 1'b1;
      rdata_ff    <= nxt_rdata;
      tx_rst_ff   <= nxt_tx_rst;
      rx_rst_ff   <= nxt_rx_rst;
      irq_ff      <= nxt_irq;
    end
  end

  // Trigger level from code and level mode
  umsfc_trig_lut u_trig
  (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_RST),
    .i_mode  (mode_ff),
    .i_code  (fcr_ff[FCR_TRIG_LSB +: 2]),
    .o_level (O_RX_TRIG_LEVEL)
  );

  // Outputs from flip-flops; the DTR, RTS and DMA outputs pass through one gate
  assign O_RDATA       = rdata_ff;
  assign O_DTR_N       = ~hcr_ff[HCR_DTR] | hcr_ff[HCR_LOOPBACK];
  assign O_RTS_N       = ~hcr_ff[HCR_RTS] | hcr_ff[HCR_LOOPBACK];
  assign O_FIFO_EN     = fcr_ff[FCR_ENABLE];
  assign O_DMA_MODE1   = fcr_ff[FCR_DMA_SEL] & fcr_ff[FCR_ENABLE];
  assign O_TX_FIFO_RST = tx_rst_ff;
  assign O_RX_FIFO_RST = rx_rst_ff;
  assign O_MODEM_IRQ   = irq_ff;

endmodule

// File: hw/umsfc_pkg.sv
// Package for the modem status and FIFO control block.
// Assumes a plain register port with one-cycle strobes.
package umsfc_pkg;

  // Register offsets (byte addresses on the plain port)
  localparam logic [3:0] ADDR_HANDSHAKE_CTRL = 4'h4;
  localparam logic [3:0] ADDR_HANDSHAKE_STAT = 4'h6;
  localparam logic [3:0] ADDR_FIFO_CTRL      = 4'h2;
  localparam logic [3:0] ADDR_INT_IDENT      = 4'h2;
  localparam logic [3:0] ADDR_INT_CTRL       = 4'h1;
  localparam logic [3:0] ADDR_LEVEL_MODE     = 4'h8;

  // Handshake control fields
  localparam int HCR_DTR      = 0;
  localparam int HCR_RTS      = 1;
  localparam int HCR_LOOP_RI  = 2;
  localparam int HCR_IRQ_EN   = 3;
  localparam int HCR_LOOPBACK = 4;

  // FIFO control fields
  localparam int FCR_ENABLE   = 0;
  localparam int FCR_RX_RST   = 1;
  localparam int FCR_TX_RST   = 2;
  localparam int FCR_DMA_SEL  = 3;
  localparam int FCR_TRIG_LSB = 6;

  // Interrupt control field
  localparam int ICR_MODEM_EN = 3;

  // Reset values
  localparam logic [7:0] HCR_RESET  = 8'h00;
  localparam logic [7:0] FCR_RESET  = 8'h00;
  localparam logic [7:0] ICR_RESET  = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // Interrupt identity codes
  localparam logic [3:0] IID_NONE   = 4'h1;
  localparam logic [3:0] IID_MODEM  = 4'h0;
  localparam logic [1:0] FIFO_ON_ID = 2'h3;

  // Unmapped reads return zero
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Modem inputs as seen after loopback muxing (active high)
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } umsfc_modem_s;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } umsfc_req_s;

endpackage

// File: hw/umsfc_trig_lut.sv
// Receive trigger level lookup, registered output.
// Assumes codes come from control registers on the same clock.
`timescale 1ns/1ps
module umsfc_trig_lut
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_mode,
  input  wire logic [1:0] i_code,
  output logic      [6:0] o_level
);

  logic [6:0] nxt_level;
  logic [6:0] level_ff;

  // Table of byte counts by mode and code
  always_comb
  begin
    case ({i_mode, i_code})
      4'h0: nxt_level = 7'h01;
      4'h1: nxt_level = 7'h04;
      4'h2: nxt_level = 7'h08;
      4'h3: nxt_level = 7'h0E;
      4'h4: nxt_level = 7'h10;
      4'h5: nxt_level = 7'h20;
      4'h6: nxt_level = 7'h30;
      4'h7: nxt_level = 7'h40;
      4'h8: nxt_level = 7'h50;
      4'h9: nxt_level = 7'h58;
      4'hA: nxt_level = 7'h60;
      4'hB: nxt_level = 7'h68;
      4'hC: nxt_level = 7'h70;
      4'hD: nxt_level = 7'h74;
      4'hE: nxt_level = 7'h78;
      default: nxt_level = 7'h7C;
    endcase
  end

  // Register the level
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      level_ff <= 7'h01;
    else
      level_ff <= nxt_level;
  end

  assign o_level = level_ff;

endmodule

// File: bench/umsfc_modem_model.sv
// Modem partner model driving the four active-low handshake inputs.
// Assumes the bench sets the asserted levels on the system clock.
`timescale 1ns/1ps
module umsfc_modem_model
(
  input  wire logic       i_clk,
  input  wire logic [3:0] i_lvl,
  output logic      [3:0] o_pin_n
);
  // Idle modem holds every line deasserted (high)
  initial o_pin_n = 4'hF;
  // Pins move just after an edge, as a synchronous modem would
  always @(posedge i_clk)
  begin
    o_pin_n <= ~i_lvl;
  end
endmodule

// File: bench/umsfc_top_props.sv
// Checker for the modem status and FIFO control block.
// Assumes binding to umsfc_top; it sees only that module's ports.
`timescale 1ns/1ps
module umsfc_top_props
  import umsfc_pkg::*;
(
  input wire logic       I_CLK_SYS,
  input wire logic       I_RST,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic       I_WR,
  input wire logic       I_RD,
  input wire logic       I_DCD_N,
  input wire logic       I_RI_N,
  input wire logic       I_DSR_N,
  input wire logic       I_CTS_N,
  input wire logic [7:0] O_RDATA,
  input wire logic       O_FIFO_EN,
  input wire logic       O_DMA_MODE1,
  input wire logic       O_TX_FIFO_RST,
  input wire logic       O_RX_FIFO_RST,
  input wire logic       O_MODEM_IRQ
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  logic [4:0] hcr_ff, nxt_hcr;
  logic [2:1] fcr_ff, nxt_fcr;
  logic       icr_ff, nxt_icr;
  logic       wf, rs;
  logic [3:0] st;
  // Shadow copies of the written control bits
  assign wf = I_WR && I_ADDR == ADDR_FIFO_CTRL;
  assign rs = I_RD && I_ADDR == ADDR_HANDSHAKE_STAT;
  assign st = hcr_ff[4] ? {hcr_ff[3], hcr_ff[2], hcr_ff[0], hcr_ff[1]}
                        : ~{I_DCD_N, I_RI_N, I_DSR_N, I_CTS_N};
  always_comb
  begin
    nxt_hcr = (I_WR && I_ADDR == ADDR_HANDSHAKE_CTRL) ? I_WDATA[4:0] : hcr_ff;
    nxt_fcr = wf ? I_WDATA[2:1] : fcr_ff;
    nxt_icr = (I_WR && I_ADDR == ADDR_INT_CTRL) ? I_WDATA[3] : icr_ff;
  end
  always_ff @(posedge I_CLK_SYS)
  begin
    hcr_ff <= I_RST ? 5'h00 : nxt_hcr;
    fcr_ff <= I_RST ? 2'h0 : nxt_fcr;
    icr_ff <= I_RST ? 1'b0 : nxt_icr;
  end
  AST_STAT_LEVELS: assert property (rs |=> O_RDATA[7:4] == $past(st))
    else $error("status levels wrong");
  AST_RDATA_IDLE: assert property (!$past(I_RD) |-> O_RDATA == READ_ZERO)
    else $error("read data outside read");
  AST_FIFO_EN: assert property (wf |=> O_FIFO_EN == $past(I_WDATA[0]))
    else $error("fifo enable wrong");
  AST_DMA_SEL: assert property (wf |=> O_DMA_MODE1 ==
    ($past(I_WDATA[3]) && $past(I_WDATA[0])))
    else $error("dma mode wrong");
  AST_TX_RISE: assert property (wf |=> O_TX_FIFO_RST ==
    ($past(I_WDATA[2]) && !$past(fcr_ff[2])))
    else $error("tx reset pulse wrong");
  AST_RX_RISE: assert property (wf |=> O_RX_FIFO_RST ==
    ($past(I_WDATA[1]) && !$past(fcr_ff[1])))
    else $error("rx reset pulse wrong");
  AST_TX_ONE: assert property (O_TX_FIFO_RST |=> !O_TX_FIFO_RST)
    else $error("tx reset pulse too long");
  AST_IDENT_HI: assert property (I_RD && I_ADDR == ADDR_INT_IDENT |=>
    O_RDATA[7:4] == {{2{$past(O_FIFO_EN)}}, 2'b00})
    else $error("identity high bits wrong");
  AST_IRQ_GATE: assert property (!$past(icr_ff) |-> !O_MODEM_IRQ)
    else $error("modem irq while disabled");
  cover property (O_TX_FIFO_RST && O_RX_FIFO_RST);
  cover property (O_MODEM_IRQ);
  cover property (rs && hcr_ff[4]);
endmodule
bind umsfc_top umsfc_top_props i_props (.I_CLK_SYS, .I_RST, .I_ADDR,
  .I_WDATA, .I_WR, .I_RD, .I_DCD_N, .I_RI_N, .I_DSR_N, .I_CTS_N, .O_RDATA,
  .O_FIFO_EN, .O_DMA_MODE1, .O_TX_FIFO_RST, .O_RX_FIFO_RST, .O_MODEM_IRQ);

// File: bench/uart_modem_status_fifo_control_tb_top.sv
// Bench top for the modem status and FIFO control block.
// Assumes umsfc_top with its bound checker and the modem model.
`timescale 1ns/1ps
module uart_modem_status_fifo_control_tb_top;
  import umsfc_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0, lvl = 4'h0, pin_n;
  logic [7:0] wdata = 8'h00, rdata, fo;
  logic       fen, dma, txr, rxr, irq, dtr_n, rts_n;
  logic [6:0] trig;
  int         fails = 0, n_tests = 0, cyc = 0;
  localparam logic [6:0] LVL_T [16] = '{7'h01, 7'h04, 7'h08, 7'h0E,
    7'h10, 7'h20, 7'h30, 7'h40, 7'h50, 7'h58, 7'h60, 7'h68,
    7'h70, 7'h74, 7'h78, 7'h7C};
  assign fo = {4'h0, txr, rxr, dma, fen};
  umsfc_top i_dut (.I_CLK_SYS(clk), .I_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_DCD_N(pin_n[3]),
    .I_RI_N(pin_n[2]), .I_DSR_N(pin_n[1]), .I_CTS_N(pin_n[0]),
    .O_RDATA(rdata), .O_DTR_N(dtr_n), .O_RTS_N(rts_n), .O_FIFO_EN(fen),
    .O_DMA_MODE1(dma), .O_TX_FIFO_RST(txr), .O_RX_FIFO_RST(rxr),
    .O_RX_TRIG_LEVEL(trig), .O_MODEM_IRQ(irq));
  umsfc_modem_model i_modem (.i_clk(clk), .i_lvl(lvl), .o_pin_n(pin_n));
  // 200 MHz clock and a hang guard
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic wr_fo(input logic [7:0] v, input logic [7:0] exp);
    wr_reg(ADDR_FIFO_CTRL, v);
    #1;
    chk(fo, exp);
  endtask
  task automatic do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(fo, 8'h00);
    chk({1'b0, trig}, 8'h01);
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence: pins, interrupt, loopback, FIFO control, levels
  initial
  begin
    do_reset(10);
    rd_chk(ADDR_HANDSHAKE_STAT, 8'h00);
    lvl = 4'hF;
    repeat (3) @(posedge clk);
    rd_chk(ADDR_HANDSHAKE_STAT, 8'hFB);
    rd_chk(ADDR_HANDSHAKE_STAT, 8'hF0);
    lvl = 4'h0;
    repeat (3) @(posedge clk);
    rd_chk(ADDR_HANDSHAKE_STAT, 8'h0F);
    wr_reg(ADDR_INT_CTRL, 8'h08);
    // Pins change by non-blocking assignment so the model sees no race
    lvl <= 4'h1;
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, irq}, 8'h01);
    rd_chk(ADDR_INT_IDENT, 8'h00);
    rd_chk(ADDR_HANDSHAKE_STAT, 8'h11);
    rd_chk(ADDR_INT_IDENT, 8'h01);
    lvl = 4'h0;
    wr_reg(ADDR_INT_CTRL, 8'h00);
    rd_chk(ADDR_HANDSHAKE_STAT, 8'h01);
    // Loopback ignores the asserted pins
    wr_reg(ADDR_HANDSHAKE_CTRL, 8'h1F);
    lvl <= 4'hF;
    #1;
    chk({6'h00, dtr_n, rts_n}, 8'h03);
    rd_chk(ADDR_HANDSHAKE_STAT, 8'hFB);
    wr_reg(ADDR_HANDSHAKE_CTRL, 8'h15);
    rd_chk(ADDR_HANDSHAKE_STAT, 8'h69);
    wr_reg(ADDR_HANDSHAKE_CTRL, 8'h10);
    rd_chk(ADDR_HANDSHAKE_STAT, 8'h06);
    wr_reg(ADDR_HANDSHAKE_CTRL, 8'h00);
    rd_chk(ADDR_HANDSHAKE_STAT, 8'hFB);
    // Modem outputs follow the control bits outside loopback
    wr_reg(ADDR_HANDSHAKE_CTRL, 8'h03);
    #1;
    chk({6'h00, dtr_n, rts_n}, 8'h00);
    wr_fo(8'h01, 8'h01);
    rd_chk(ADDR_FIFO_CTRL, 8'hC1);
    wr_fo(8'h0F, 8'h0F);
    wr_fo(8'h0F, 8'h03);
    wr_fo(8'h09, 8'h03);
    wr_fo(8'h0D, 8'h0B);
    wr_fo(8'h08, 8'h00);
    rd_chk(ADDR_INT_IDENT, 8'h01);
    rd_chk(4'hF, 8'h00);
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 4; c++)
      begin
        wr_reg(ADDR_LEVEL_MODE, {m[1:0], 6'h00});
        wr_reg(ADDR_FIFO_CTRL, {c[1:0], 6'h01});
        repeat (3) @(posedge clk);
        #1;
        chk({1'b0, trig}, {1'b0, LVL_T[m * 4 + c]});
      end
    @(posedge clk);
    do_reset(2);
    final_report();
  end
endmodule
